// File: design/node_io_link_map_registers.sv
// node link status and memory-mapped i/o range map register bank
`timescale 1ns/10ps
module node_io_link_map_registers (
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	input  wire logic [2:0]                    node_id,
	input  wire logic [node_map_pkg::NUM_LINKS-1:0] link_connected,
	input  wire logic [node_map_pkg::NUM_LINKS-1:0] link_init_complete,
	input  wire logic [node_map_pkg::NUM_LINKS-1:0] link_noncoherent,
	input  wire logic [node_map_pkg::NUM_LINKS-1:0] link_connect_pending,
	input  wire logic                          cfg_req,
	input  wire logic                          cfg_wr,
	input  wire logic [7:0]                    cfg_bus,
	input  wire logic [4:0]                    cfg_dev,
	input  wire logic [2:0]                    cfg_func,
	input  wire logic [11:0]                   cfg_ofs,
	input  wire logic [31:0]                   cfg_wdata,
	output logic                               cfg_ack_r,
	output logic [31:0]                        cfg_rdata_r,
	input  wire logic                          phys_req,
	input  wire logic                          phys_wr,
	input  wire logic [47:0]                   phys_addr,
	output logic                               hit_r,
	output logic [2:0]                         target_node_id_r,
	output logic [3:0]                         hit_range_r
);
	import node_map_pkg::*;

	// ==========================================================
	// link status synchronisers
	logic [3:0] lt_in [0:NUM_LINKS-1];            // raw pins per link
	logic [3:0] s1_r [0:NUM_LINKS-1];             // first stage
	logic [3:0] s2_r [0:NUM_LINKS-1];             // second stage
	logic [3:0] s3_r [0:NUM_LINKS-1];             // third stage
	logic [3:0] st_r [0:NUM_LINKS-1];             // accepted value
	logic [3:0] st_nxt [0:NUM_LINKS-1];
	genvar g;
	generate
		for (g = 0; g < NUM_LINKS; g++) begin : g_link
			assign lt_in[g] = {link_connect_pending[g], link_noncoherent[g],
				link_init_complete[g], link_connected[g]};
			// a change counts only once stages two and three agree
			always_comb begin
				st_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : st_r[g];
			end
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					s1_r[g] <= 4'h0;
					s2_r[g] <= 4'h0;
					s3_r[g] <= 4'h0;
					st_r[g] <= 4'h0;
				end else begin
					s1_r[g] <= lt_in[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					st_r[g] <= st_nxt[g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// range storage
	logic [23:0] base_addr_r [0:NUM_RANGES-1];    // io_range_base_addr low
	logic [23:0] limit_addr_r [0:NUM_RANGES-1];   // io_range_limit_addr low
	logic [7:0]  limit_ctl_r [0:NUM_RANGES-1];    // route bits, target node
	logic [7:0]  base_hi_r [0:NUM_RANGES-1];      // base bits 47:40
	logic [7:0]  limit_hi_r [0:NUM_RANGES-1];     // limit bits 47:40
	logic [1:0]  en_r [0:NUM_RANGES-1];           // write, read decode enable
	logic [23:0] base_addr_nxt [0:NUM_RANGES-1];
	logic [23:0] limit_addr_nxt [0:NUM_RANGES-1];
	logic [7:0]  limit_ctl_nxt [0:NUM_RANGES-1];
	logic [7:0]  base_hi_nxt [0:NUM_RANGES-1];
	logic [7:0]  limit_hi_nxt [0:NUM_RANGES-1];
	logic [1:0]  en_nxt [0:NUM_RANGES-1];
	logic [2:0]  my_node_r;                       // strap caught in reset
	logic        cfg_ack_nxt;
	logic [31:0] cfg_rdata_nxt;
	logic        ours;                            // access aimed at this node

	// bus 0, device 24 plus node number, functions 0 and 1 only
	assign ours = (cfg_bus == CFG_BUS) && (cfg_dev == (CFG_DEV_BASE + {2'b00, my_node_r}));

	// ==========================================================
	// configuration access decode
	always_comb begin
		cfg_ack_nxt   = cfg_req;
		cfg_rdata_nxt = 32'h00000000;                 // unmapped reads zero
		for (int i = 0; i < NUM_RANGES; i++) begin
			base_addr_nxt[i]  = base_addr_r[i];
			limit_addr_nxt[i] = limit_addr_r[i];
			limit_ctl_nxt[i]  = limit_ctl_r[i];
			base_hi_nxt[i]    = base_hi_r[i];
			limit_hi_nxt[i]   = limit_hi_r[i];
			en_nxt[i]         = en_r[i];
		end
		if (cfg_req && ours && cfg_func == FUNC_LINK) begin
			// link status is read-only; writes fall away
			for (int l = 0; l < NUM_LINKS; l++) begin
				if (cfg_ofs == LINK_TYPE_OFS[l]) begin
					cfg_rdata_nxt[LT_CONNECTED]     = st_r[l][0];
					cfg_rdata_nxt[LT_NONCOHERENT]   = st_r[l][2];
					cfg_rdata_nxt[LT_INIT_COMPLETE] = st_r[l][1];
					cfg_rdata_nxt[LT_PENDING]       = st_r[l][3];
				end
			end
		end else if (cfg_req && ours && cfg_func == FUNC_MAP) begin
			for (int i = 0; i < NUM_RANGES; i++) begin
				if (cfg_ofs == RANGE_BASE_OFS[i]) begin
					// lock reads zero: nothing here locks the map
					cfg_rdata_nxt = {base_addr_r[i], 6'h00, en_r[i]};
					if (cfg_wr) begin
						base_addr_nxt[i] = cfg_wdata[31:ADDR_LSB];
						en_nxt[i] = {cfg_wdata[BASE_WR_EN], cfg_wdata[BASE_RD_EN]};
					end
				end else if (cfg_ofs == RANGE_BASE_OFS[i] + LIMIT_OFS_STEP) begin
					cfg_rdata_nxt = {limit_addr_r[i], limit_ctl_r[i]};
					if (cfg_wr) begin
						limit_addr_nxt[i] = cfg_wdata[31:ADDR_LSB];
						limit_ctl_nxt[i]  = cfg_wdata[7:0];
					end
				end else if (cfg_ofs == RANGE_HIGH_OFS[i]) begin
					cfg_rdata_nxt = {8'h00, limit_hi_r[i], 8'h00, base_hi_r[i]};
					if (cfg_wr) begin
						base_hi_nxt[i]  = cfg_wdata[HIGH_BASE_LSB +: 8];
						limit_hi_nxt[i] = cfg_wdata[HIGH_LIMIT_LSB +: 8];
					end
				end
			end
		end
	end

	// register stage; node number is taken while reset is held
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			my_node_r   <= node_id;
			cfg_ack_r   <= 1'b0;
			cfg_rdata_r <= 32'h00000000;
			for (int i = 0; i < NUM_RANGES; i++) begin
				base_addr_r[i]  <= ADDR_RST;
				limit_addr_r[i] <= ADDR_RST;
				limit_ctl_r[i]  <= BYTE_RST;
				base_hi_r[i]    <= BYTE_RST;
				limit_hi_r[i]   <= BYTE_RST;
				en_r[i]         <= 2'b00;
			end
		end else begin
			cfg_ack_r   <= cfg_ack_nxt;
			cfg_rdata_r <= cfg_rdata_nxt;
			for (int i = 0; i < NUM_RANGES; i++) begin
				base_addr_r[i]  <= base_addr_nxt[i];
				limit_addr_r[i] <= limit_addr_nxt[i];
				limit_ctl_r[i]  <= limit_ctl_nxt[i];
				base_hi_r[i]    <= base_hi_nxt[i];
				limit_hi_r[i]   <= limit_hi_nxt[i];
				en_r[i]         <= en_nxt[i];
			end
		end
	end

	// ==========================================================
	// address range decode
	logic [47:0] full_base [0:NUM_RANGES-1];      // 64K aligned base
	logic [47:0] full_limit [0:NUM_RANGES-1];     // limit, low bits ones
	logic [NUM_RANGES-1:0] match;
	generate
		for (g = 0; g < NUM_RANGES; g++) begin : g_range
			assign full_base[g]  = {base_hi_r[g], base_addr_r[g], 16'h0000};
			assign full_limit[g] = {limit_hi_r[g], limit_addr_r[g], LIMIT_LOW_FILL};
			assign match[g] = phys_req
				&& (phys_wr ? en_r[g][1] : en_r[g][0])
				&& (phys_addr > full_base[g]) && (phys_addr <= full_limit[g]);
		end
	endgenerate

	logic       hit_nxt;
	logic [2:0] node_nxt;
	logic [3:0] range_nxt;
	// lowest numbered matching range wins if ranges overlap
	always_comb begin
		hit_nxt   = 1'b0;
		node_nxt  = 3'h0;
		range_nxt = 4'h0;
		for (int i = NUM_RANGES - 1; i >= 0; i--) begin
			if (match[i]) begin
				hit_nxt   = 1'b1;
				node_nxt  = limit_ctl_r[i][NODE_ID_W-1:0];
				range_nxt = 4'(i);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hit_r            <= 1'b0;
			target_node_id_r <= 3'h0;
			hit_range_r      <= 4'h0;
		end else begin
			hit_r            <= hit_nxt;
			target_node_id_r <= node_nxt;
			hit_range_r      <= range_nxt;
		end
	end

	// ==========================================================
	// checks
	logic link_rd_r;   // last cycle accessed the link 0 status register
	logic base_rd_r;   // last cycle accessed the range 0 base register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			link_rd_r <= 1'b0;
			base_rd_r <= 1'b0;
		end else begin
			link_rd_r <= cfg_req && ours && cfg_func == FUNC_LINK && cfg_ofs == LINK_TYPE_OFS[0];
			base_rd_r <= cfg_req && ours && cfg_func == FUNC_MAP && cfg_ofs == RANGE_BASE_OFS[0];
		end
	end

	AST_ACK_NEXT: assert property (@(posedge clk) disable iff (!rst_b)
		cfg_req |=> cfg_ack_r) else $error("config request not answered");
	AST_FOREIGN_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
		cfg_req && !ours |=> cfg_rdata_r == 32'h00000000) else $error("foreign access data");
	AST_LINK_BITS: assert property (@(posedge clk) disable iff (!rst_b)
		link_rd_r |-> cfg_rdata_r[0] == $past(st_r[0][0]) && cfg_rdata_r[2] == $past(st_r[0][2]))
		else $error("link status bits wrong");
	AST_LINK_RES: assert property (@(posedge clk) disable iff (!rst_b)
		link_rd_r |-> cfg_rdata_r[31:5] == 27'h0 && !cfg_rdata_r[3]) else $error("link reserved set");
	AST_BASE_RES: assert property (@(posedge clk) disable iff (!rst_b)
		base_rd_r |-> cfg_rdata_r[7:2] == 6'h00) else $error("base reserved bits set");
	AST_BASE_WR: assert property (@(posedge clk) disable iff (!rst_b)
		cfg_req && cfg_wr && ours && cfg_func == FUNC_MAP && cfg_ofs == RANGE_BASE_OFS[0]
		|=> base_addr_r[0] == $past(cfg_wdata[31:8]) && en_r[0] == $past(cfg_wdata[1:0]))
		else $error("base write lost");
	AST_HIT_BOUNDS: assert property (@(posedge clk) disable iff (!rst_b)
		hit_nxt |-> phys_addr > full_base[range_nxt] && phys_addr <= full_limit[range_nxt])
		else $error("hit outside range");
	AST_HIT_NODE: assert property (@(posedge clk) disable iff (!rst_b)
		hit_r |-> target_node_id_r == $past(limit_ctl_r[range_nxt][2:0]))
		else $error("wrong target node");
	AST_FULL_LIMIT: assert property (@(posedge clk) disable iff (!rst_b)
		phys_req && !phys_wr && en_r[0][0] && phys_addr > full_base[0]
		&& phys_addr[47:16] == {limit_hi_r[0], limit_addr_r[0]} |=> hit_r)
		else $error("limit low bits not ones");
	AST_NO_REQ_NO_HIT: assert property (@(posedge clk) disable iff (!rst_b)
		!phys_req |=> !hit_r) else $error("hit without request");

	COV_LINK_RD: cover property (@(posedge clk) disable iff (!rst_b) link_rd_r);
	COV_BASE_WR_HIT: cover property (@(posedge clk) disable iff (!rst_b)
		base_rd_r ##[1:20] hit_r);
	COV_HIT_HIGH: cover property (@(posedge clk) disable iff (!rst_b)
		hit_r && hit_range_r >= 4'h8);
endmodule : node_io_link_map_registers

// File: design/node_map_pkg.sv
// constants for the node link status and i/o range map registers
package node_map_pkg;
	// ==========================================================
	// sizes
	localparam int NUM_LINKS  = 4;   // i/o links per node
	localparam int NUM_RANGES = 12;  // memory-mapped i/o ranges
	localparam int SYNC_DEPTH = 3;   // pin synchroniser stages
	// ==========================================================
	// configuration-space identity
	localparam logic [7:0] CFG_BUS      = 8'h00;  // nodes sit on bus 0
	localparam logic [4:0] CFG_DEV_BASE = 5'h18;  // node 0 device number
	localparam logic [2:0] FUNC_LINK    = 3'h0;   // link status function
	localparam logic [2:0] FUNC_MAP     = 3'h1;   // address map function
	// ==========================================================
	// register offsets
	localparam logic [11:0] LINK_TYPE_OFS [0:NUM_LINKS-1] = '{
		12'h098, 12'h0B8, 12'h0D8, 12'h0F8};
	localparam logic [11:0] RANGE_BASE_OFS [0:NUM_RANGES-1] = '{
		12'h080, 12'h088, 12'h090, 12'h098, 12'h0A0, 12'h0A8,
		12'h0B0, 12'h0B8, 12'h1A0, 12'h1A8, 12'h1B0, 12'h1B8};
	localparam logic [11:0] RANGE_HIGH_OFS [0:NUM_RANGES-1] = '{
		12'h180, 12'h184, 12'h188, 12'h18C, 12'h190, 12'h194,
		12'h198, 12'h19C, 12'h1C0, 12'h1C4, 12'h1C8, 12'h1CC};
	localparam logic [11:0] LIMIT_OFS_STEP = 12'h004;  // limit follows base
	// ==========================================================
	// field positions
	localparam int LT_CONNECTED     = 0;
	localparam int LT_INIT_COMPLETE = 1;
	localparam int LT_NONCOHERENT   = 2;
	localparam int LT_PENDING       = 4;
	localparam int BASE_RD_EN       = 0;
	localparam int BASE_WR_EN       = 1;
	localparam int BASE_LOCK        = 3;
	localparam int ADDR_LSB         = 8;   // low regs bits 31:8
	localparam int HIGH_BASE_LSB    = 0;   // high reg bits 7:0
	localparam int HIGH_LIMIT_LSB   = 16;  // high reg bits 23:16
	localparam int NODE_ID_W        = 3;   // limit reg bits 2:0
	// ==========================================================
	// reset values and compare fill
	localparam logic [23:0] ADDR_RST      = 24'h000000;
	localparam logic [7:0]  BYTE_RST      = 8'h00;
	localparam logic [15:0] LIMIT_LOW_FILL = 16'hFFFF;
endpackage : node_map_pkg

// File: verif/node_io_link_map_registers_tb_top.sv
// self-checking bench for the node link status and i/o range map registers
`timescale 1ns/10ps
module node_io_link_map_registers_tb_top;
	import node_map_pkg::*;
	// ==========================================================
	// stimulus and observation signals
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  lk_con = 4'h0, lk_ic = 4'h0, lk_nc = 4'h0, lk_pend = 4'h0;
	logic        cfg_req = 1'b0, cfg_wr = 1'b0;
	logic [7:0]  cfg_bus = 8'h00;
	logic [4:0]  cfg_dev = 5'h00;
	logic [2:0]  cfg_func = 3'h0;
	logic [11:0] cfg_ofs = 12'h000;
	logic [31:0] cfg_wdata = 32'h0, cfg_rdata_r, rd;
	logic        cfg_ack_r, phys_req = 1'b0, phys_wr = 1'b0, hit_r;
	logic [47:0] phys_addr = 48'h0;
	logic [2:0]  target_node_id_r;
	logic [3:0]  hit_range_r;
	logic [7:0]  t_bus = 8'h00;  // address used by the cfg task
	logic [4:0]  t_dev = 5'h1A;  // strap 2 gives device 26
	logic [2:0]  strap = 3'h2;   // node number strap, caught in reset
	int          err_total = 0, num_checks = 0, cyc = 0;
	// ==========================================================
	// clock and hang guard
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin  // far beyond the 95 or so cycles needed
			err_total++;
			print_verdict();
		end
	end
	node_io_link_map_registers DUT (.clk(clk), .rst_b(rst_b), .node_id(strap),
		.link_connected(lk_con), .link_init_complete(lk_ic), .link_noncoherent(lk_nc),
		.link_connect_pending(lk_pend), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
		.cfg_bus(cfg_bus), .cfg_dev(cfg_dev), .cfg_func(cfg_func), .cfg_ofs(cfg_ofs),
		.cfg_wdata(cfg_wdata), .cfg_ack_r(cfg_ack_r), .cfg_rdata_r(cfg_rdata_r),
		.phys_req(phys_req), .phys_wr(phys_wr), .phys_addr(phys_addr), .hit_r(hit_r),
		.target_node_id_r(target_node_id_r), .hit_range_r(hit_range_r));
	// ==========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one config access, answer one edge later
	task automatic cfg(input logic w, input logic [2:0] f, input logic [11:0] o,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		cfg_req <= 1'b1;
		cfg_wr <= w;
		cfg_bus <= t_bus;
		cfg_dev <= t_dev;
		cfg_func <= f;
		cfg_ofs <= o;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_req <= 1'b0;
		#1;
		chk("cfg_ack", 48'h1, {47'h0, cfg_ack_r});
		r = cfg_rdata_r;
	endtask : cfg
	// one decode request, result one edge later
	task automatic dec(input logic w, input logic [47:0] a, input logic eh,
		input logic [2:0] en, input logic [3:0] er);
		@(posedge clk);
		phys_req <= 1'b1;
		phys_wr <= w;
		phys_addr <= a;
		@(posedge clk);
		phys_req <= 1'b0;
		#1;
		chk("hit", {47'h0, eh}, {47'h0, hit_r});
		chk("node", {45'h0, en}, {45'h0, target_node_id_r});
		chk("range", {44'h0, er}, {44'h0, hit_range_r});
	endtask : dec
	// ==========================================================
	// scenarios
	task automatic link_status;
		lk_con <= 4'hB;
		lk_ic <= 4'h6;
		lk_nc <= 4'hC;
		lk_pend <= 4'h3;
		repeat (8) @(posedge clk);  // synchroniser settle
		for (int l = 0; l < 4; l++) begin
			cfg(1'b1, FUNC_LINK, LINK_TYPE_OFS[l], 32'hFFFFFFFF, rd);
			cfg(1'b0, FUNC_LINK, LINK_TYPE_OFS[l], 32'h0, rd);
			chk("link", {16'h0, 27'h0, lk_pend[l], 1'b0, lk_nc[l], lk_ic[l], lk_con[l]},
				{16'h0, rd});
		end
	endtask : link_status
	task automatic foreign_dev;
		t_dev = 5'h1B;
		cfg(1'b0, FUNC_LINK, 12'h098, 32'h0, rd);
		chk("wrong_dev", 48'h0, {16'h0, rd});
		t_dev = 5'h1A;
		t_bus = 8'h01;
		cfg(1'b0, FUNC_LINK, 12'h098, 32'h0, rd);
		chk("wrong_bus", 48'h0, {16'h0, rd});
		t_bus = 8'h00;
		// link status lives in function 0 only
		cfg(1'b0, 3'h2, 12'h098, 32'h0, rd);
		chk("wrong_func", 48'h0, {16'h0, rd});
	endtask : foreign_dev
	task automatic base_fields;
		cfg(1'b0, FUNC_MAP, RANGE_BASE_OFS[0], 32'h0, rd);
		chk("base_rst", 48'h0, {16'h0, rd});
		cfg(1'b1, FUNC_MAP, RANGE_BASE_OFS[0], 32'hFFFFFFFF, rd);
		cfg(1'b0, FUNC_MAP, RANGE_BASE_OFS[0], 32'h0, rd);
		chk("base_rw", 48'hFFFFFF03, {16'h0, rd});
		cfg(1'b1, FUNC_MAP, RANGE_BASE_OFS[0], 32'h0, rd);
	endtask : base_fields
	task automatic decode_range;
		cfg(1'b1, FUNC_MAP, RANGE_BASE_OFS[9], 32'h00123403, rd);
		cfg(1'b1, FUNC_MAP, RANGE_BASE_OFS[9] + LIMIT_OFS_STEP, 32'h00123505, rd);
		cfg(1'b1, FUNC_MAP, RANGE_HIGH_OFS[9], 32'h00AB00AB, rd);
		cfg(1'b0, FUNC_MAP, RANGE_HIGH_OFS[9], 32'h0, rd);
		chk("high", 48'h00AB00AB, {16'h0, rd});
		cfg(1'b0, FUNC_MAP, RANGE_BASE_OFS[9] + LIMIT_OFS_STEP, 32'h0, rd);
		chk("limit", 48'h00123505, {16'h0, rd});
		dec(1'b0, 48'hAB0012340000, 1'b0, 3'h0, 4'h0);
		dec(1'b0, 48'hAB0012340001, 1'b1, 3'h5, 4'h9);
		dec(1'b1, 48'hAB001235FFFF, 1'b1, 3'h5, 4'h9);
		dec(1'b0, 48'hAB0012360000, 1'b0, 3'h0, 4'h0);
		dec(1'b0, 48'hAC0012340001, 1'b0, 3'h0, 4'h0);
		cfg(1'b1, FUNC_MAP, RANGE_BASE_OFS[9], 32'h00123401, rd);
		dec(1'b1, 48'hAB0012348000, 1'b0, 3'h0, 4'h0);
		dec(1'b0, 48'hAB0012348000, 1'b1, 3'h5, 4'h9);
		// range 0: read decode only, limit one 64K block above base
		cfg(1'b1, FUNC_MAP, RANGE_BASE_OFS[0], 32'h00000101, rd);
		cfg(1'b1, FUNC_MAP, RANGE_BASE_OFS[0] + LIMIT_OFS_STEP, 32'h00000203, rd);
		cfg(1'b0, FUNC_MAP, RANGE_BASE_OFS[0], 32'h0, rd);
		chk("base0", 48'h00000101, {16'h0, rd});
		dec(1'b0, 48'h000000028000, 1'b1, 3'h3, 4'h0);
		dec(1'b1, 48'h000000028000, 1'b0, 3'h0, 4'h0);
	endtask : decode_range
	// second reset with a new strap; the strap moves after release
	task automatic reset_restrap;
		@(posedge clk);
		strap <= 3'h7;
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		strap <= 3'h0;
		repeat (8) @(posedge clk);  // synchroniser settle
		t_dev = 5'h1F;
		cfg(1'b0, FUNC_LINK, LINK_TYPE_OFS[0], 32'h0, rd);
		chk("restrap_link", 48'h11, {16'h0, rd});
		cfg(1'b0, FUNC_MAP, RANGE_BASE_OFS[9], 32'h0, rd);
		chk("base_after_rst", 48'h0, {16'h0, rd});
		t_dev = 5'h1A;
		cfg(1'b0, FUNC_LINK, LINK_TYPE_OFS[0], 32'h0, rd);
		chk("old_dev", 48'h0, {16'h0, rd});
	endtask : reset_restrap
	// ==========================================================
	// verdict
	task automatic print_verdict;
		if (err_total == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict
	// ==========================================================
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		link_status();
		foreign_dev();
		base_fields();
		decode_range();
		reset_restrap();
		print_verdict();
	end
endmodule : node_io_link_map_registers_tb_top
